/* design/pdu_consts.vh */
// Register offsets, field positions and reset values of the duty and dead-time unit.
`ifndef PDU_CONSTS_VH
`define PDU_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PDU_OFS_TB_CTRL 6'h00
`define PDU_OFS_PERIOD 6'h04
`define PDU_OFS_COUNT 6'h08
`define PDU_OFS_OUT_CTRL1 6'h0C
`define PDU_OFS_OUT_CTRL2 6'h10
`define PDU_OFS_DT_CFG1 6'h14
`define PDU_OFS_DT_ASSIGN 6'h18
`define PDU_OFS_OVERRIDE 6'h1C
`define PDU_OFS_DUTY_BASE 6'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define PDU_TB_RUN_BIT 15
`define PDU_TB_DIR_BIT 14
`define PDU_LOCKOUT_BIT 0
`define PDU_OVR_EN_LSB 8

// ****************************************************************
// Time-base mode codes
// ****************************************************************
`define PDU_MODE_FREE 2'b00
`define PDU_MODE_UPDOWN 2'b01
`define PDU_MODE_SINGLE 2'b10
`define PDU_MODE_DOUBLE 2'b11

// ****************************************************************
// Reset values
// ****************************************************************
`define PDU_RST_16 16'h0000
`define PDU_RST_15 15'h0000
`define PDU_RST_8 8'h00
`define PDU_RST_6 6'h00
`define PDU_RST_4 4'h0
`define PDU_RST_3 3'h0
`define PDU_RST_2 2'h0

`endif

/* design/pdu_top.v */
// Duty comparison, output pairing and dead-time unit with its time base and AHB-Lite registers.
// Overview of operation
// - Four 16-bit duty registers, one per generator.
// - Duty LSB gives half-interval edge placement.
// - Duty written to buffer, hidden compare used.
// - Edge mode loads compare at period rollover.
// - Edge mode stopped, unlocked: copy continuously.
// - Up/down loads at zero turning upward.
// - Double update loads at zero and period.
// - Up/down modes copy while time base stopped.
// - Generator n drives pair n, low complemented.
// - Select bit clear means complementary, reset default.
// - Dead-time holds both outputs inactive at switching.
// - Two dead-times A and B, freely allotted.
// - Per-pair 6-bit down counter loaded on edges.
// - Per-pair bits pick A/B per edge direction.
// - Per-dead-time prescale of 1,2,4,8 cycles.
// - Two 6-bit counts held in first config register.
// - Prescalers cleared on load, config write, reset.
// - Select bit set: independent, no dead-time.
// - Independent: one generator feeds both, override choices.
// - Mode code 10 single pulse, active on run.
// - Single pulse: duty match off, period ends all.
// - Edge mode active from zero until duty match.
`timescale 1ns/100ps
`default_nettype none
`include "pdu_consts.vh"

module pdu_top (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Gate driver outputs
  output reg [3:0] high_side_output,
  output reg [3:0] low_side_output,
  // One-cycle pulse when a single pulse ends
  output reg single_pulse_done
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  reg wr_pend_q;
  reg [5:0] addr_q;
  wire addr_take = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= `PDU_RST_6;
    end else begin
      wr_pend_q <= addr_take & hwrite;
      if (addr_take) begin
        addr_q <= {haddr[5:2], 2'b00};
      end
    end
  end

  // Any address bit above the map marks the transfer unmapped: it reads zero and writes nothing.
  wire hi_addr_q;
  reg hi_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_q <= 1'b0;
    end else if (addr_take) begin
      hi_q <= |haddr[31:6];
    end
  end
  assign hi_addr_q = hi_q;

  // Every register answers at once, so the slave never stretches a transfer.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire wr_en = wr_pend_q & ~hi_addr_q;
  wire wr_tb = wr_en & (addr_q == `PDU_OFS_TB_CTRL);
  wire wr_per = wr_en & (addr_q == `PDU_OFS_PERIOD);
  wire wr_oc1 = wr_en & (addr_q == `PDU_OFS_OUT_CTRL1);
  wire wr_oc2 = wr_en & (addr_q == `PDU_OFS_OUT_CTRL2);
  wire wr_dt1 = wr_en & (addr_q == `PDU_OFS_DT_CFG1);
  wire wr_dt2 = wr_en & (addr_q == `PDU_OFS_DT_ASSIGN);
  wire wr_ovr = wr_en & (addr_q == `PDU_OFS_OVERRIDE);
  wire wr_duty = wr_en & (addr_q[5:4] == 2'b10);
  wire [1:0] duty_idx = addr_q[3:2];

  // ****************************************************************
  // Software registers
  // ****************************************************************
  reg run_q;
  reg [1:0] mode_q;
  reg [14:0] period_q;
  reg [3:0] indep_q;
  reg lockout_q;
  reg [15:0] dt_cfg_q;
  reg [7:0] dt_assign_q;
  reg [15:0] ovr_q;
  reg [15:0] duty_buf_q [0:3];
  reg [15:0] duty_act_q [0:3];
  reg [14:0] cnt_q;
  reg ph_q;
  reg dir_q;

  wire [5:0] dt_a_len = dt_cfg_q[5:0];
  wire [1:0] dt_a_ps = dt_cfg_q[7:6];
  wire [5:0] dt_b_len = dt_cfg_q[13:8];
  wire [1:0] dt_b_ps = dt_cfg_q[15:14];
  // Either config write restarts every prescaler.
  wire dt_cfg_wr = wr_dt1 | wr_dt2;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= `PDU_RST_2;
      period_q <= `PDU_RST_15;
      indep_q <= `PDU_RST_4;
      lockout_q <= 1'b0;
      dt_cfg_q <= `PDU_RST_16;
      dt_assign_q <= `PDU_RST_8;
      ovr_q <= `PDU_RST_16;
    end else begin
      if (wr_tb) begin
        mode_q <= hwdata[1:0];
      end
      if (wr_per) begin
        period_q <= hwdata[14:0];
      end
      if (wr_oc1) begin
        indep_q <= hwdata[3:0];
      end
      if (wr_oc2) begin
        lockout_q <= hwdata[`PDU_LOCKOUT_BIT];
      end
      // Only the low half-word of the bus is significant; higher bits are dropped.
      if (wr_dt1) begin
        dt_cfg_q <= hwdata[15:0];
      end
      if (wr_dt2) begin
        dt_assign_q <= hwdata[7:0];
      end
      if (wr_ovr) begin
        ovr_q <= hwdata[15:0];
      end
    end
  end

  // ****************************************************************
  // Time base
  // ****************************************************************
  // Each count lasts two clocks; the phase bit is the half-interval step.
  // A zero period holds the count still and so freezes every compare result while the run bit is set.
  wire tb_go = run_q & (period_q != `PDU_RST_15);
  wire tick = tb_go & ph_q;
  wire updown = (mode_q == `PDU_MODE_UPDOWN) | (mode_q == `PDU_MODE_DOUBLE);
  wire per_match = tick & ~dir_q & (cnt_q == period_q);
  wire zero_turn = tick & dir_q & (cnt_q == `PDU_RST_15);
  wire single_end = per_match & (mode_q == `PDU_MODE_SINGLE);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 1'b0;
      cnt_q <= `PDU_RST_15;
      ph_q <= 1'b0;
      dir_q <= 1'b0;
      single_pulse_done <= 1'b0;
    end else begin
      // The end flag lasts one clock and coincides with the run bit reading clear.
      single_pulse_done <= single_end;
      // A software write of the run bit wins over the hardware clear.
      if (wr_tb) begin
        run_q <= hwdata[`PDU_TB_RUN_BIT];
      end else if (single_end) begin
        run_q <= 1'b0;
      end
      if (tb_go) begin
        ph_q <= ~ph_q;
      end
      if (per_match) begin
        if (updown) begin
          dir_q <= 1'b1;
          cnt_q <= cnt_q - 15'h0001;
        end else begin
          cnt_q <= `PDU_RST_15;
        end
      end else if (zero_turn) begin
        dir_q <= 1'b0;
        cnt_q <= cnt_q + 15'h0001;
      end else if (tick) begin
        cnt_q <= dir_q ? cnt_q - 15'h0001 : cnt_q + 15'h0001;
      end
    end
  end

  // ****************************************************************
  // Duty buffers and transfer
  // ****************************************************************
  reg xfer;
  always @* begin
    case (mode_q)
      `PDU_MODE_FREE, `PDU_MODE_SINGLE: begin
        xfer = ~lockout_q & (per_match | ~run_q);
      end
      // Lockout holds back only the timed loads here; a stopped time base always copies.
      `PDU_MODE_UPDOWN: begin
        xfer = (~lockout_q & zero_turn) | ~run_q;
      end
      `PDU_MODE_DOUBLE: begin
        xfer = (~lockout_q & (zero_turn | per_match)) | ~run_q;
      end
      default: begin
        xfer = 1'b0;
      end
    endcase
  end

  // Compare position in half-interval steps.
  wire [15:0] tb_pos = {cnt_q, ph_q};
  wire [3:0] cmp;
  wire [3:0] raw_h;
  wire [3:0] raw_l;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : pair
      reg cmp_q;
      reg [5:0] dcnt_q;
      reg [2:0] pre_q;
      reg [1:0] ps_q;

      wire rise = cmp[g] & ~cmp_q;
      wire fall = ~cmp[g] & cmp_q;
      wire sel_b = rise ? dt_assign_q[2*g] : dt_assign_q[2*g+1];
      wire [2:0] pre_lim = {ps_q == 2'b11, ps_q[1], |ps_q};

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          duty_buf_q[g] <= `PDU_RST_16;
          duty_act_q[g] <= `PDU_RST_16;
        end else begin
          if (wr_duty & (duty_idx == g)) begin
            duty_buf_q[g] <= hwdata[15:0];
          end
          // Software never writes the hidden compare copy; only the transfer strobe loads it.
          if (xfer) begin
            duty_act_q[g] <= duty_buf_q[g];
          end
        end
      end

      // Single pulse stays active only while the run bit is set.
      assign cmp[g] = (mode_q == `PDU_MODE_SINGLE) ? (run_q & (tb_pos < duty_act_q[g])) :
                      (tb_pos < duty_act_q[g]);

      // The prescaler runs from zero to one below its divide, then steps the down counter.
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cmp_q <= 1'b0;
          dcnt_q <= `PDU_RST_6;
          pre_q <= `PDU_RST_3;
          ps_q <= `PDU_RST_2;
        end else begin
          cmp_q <= cmp[g];
          if (rise | fall) begin
            dcnt_q <= sel_b ? dt_b_len : dt_a_len;
            ps_q <= sel_b ? dt_b_ps : dt_a_ps;
            pre_q <= `PDU_RST_3;
          end else if (dt_cfg_wr) begin
            pre_q <= `PDU_RST_3;
          end else if (dcnt_q != `PDU_RST_6) begin
            if (pre_q == pre_lim) begin
              pre_q <= `PDU_RST_3;
              dcnt_q <= dcnt_q - 6'h01;
            end else begin
              pre_q <= pre_q + 3'h1;
            end
          end
        end
      end

      // Independent pairs skip dead-time and share one generator.
      wire dt_idle = (dcnt_q == `PDU_RST_6);
      assign raw_h[g] = indep_q[g] ? cmp_q : (cmp_q & dt_idle);
      assign raw_l[g] = indep_q[g] ? cmp_q : (~cmp_q & dt_idle);

      // Override acts after dead-time, so a forced complementary pair is not re-complemented;
      // software must not force both sides of such a pair on.
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          high_side_output[g] <= 1'b0;
          low_side_output[g] <= 1'b0;
        end else begin
          high_side_output[g] <= ovr_q[`PDU_OVR_EN_LSB+2*g] ? ovr_q[2*g] : raw_h[g];
          low_side_output[g] <= ovr_q[`PDU_OVR_EN_LSB+2*g+1] ? ovr_q[2*g+1] : raw_l[g];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  // Read data follows the registered address; a read right after a write
  // to the same register already sees the new value.
  always @* begin
    hrdata = 32'h0000_0000;
    if (!hi_addr_q) begin
      case (addr_q)
        `PDU_OFS_TB_CTRL: hrdata = {16'h0000, run_q, dir_q, 12'h000, mode_q};
        `PDU_OFS_PERIOD: hrdata = {17'h0_0000, period_q};
        `PDU_OFS_COUNT: hrdata = {17'h0_0000, cnt_q};
        `PDU_OFS_OUT_CTRL1: hrdata = {28'h000_0000, indep_q};
        `PDU_OFS_OUT_CTRL2: hrdata = {31'h0000_0000, lockout_q};
        `PDU_OFS_DT_CFG1: hrdata = {16'h0000, dt_cfg_q};
        `PDU_OFS_DT_ASSIGN: hrdata = {24'h00_0000, dt_assign_q};
        `PDU_OFS_OVERRIDE: hrdata = {16'h0000, ovr_q};
        6'h20: hrdata = {16'h0000, duty_buf_q[0]};
        6'h24: hrdata = {16'h0000, duty_buf_q[1]};
        6'h28: hrdata = {16'h0000, duty_buf_q[2]};
        6'h2C: hrdata = {16'h0000, duty_buf_q[3]};
        6'h30: hrdata = {16'h0000, duty_act_q[0]};
        6'h34: hrdata = {16'h0000, duty_act_q[1]};
        6'h38: hrdata = {16'h0000, duty_act_q[2]};
        6'h3C: hrdata = {16'h0000, duty_act_q[3]};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

endmodule // pdu_top

`default_nettype wire

/* testbench/pdu_monitor.sv */
// Checker for the bus readback and gate outputs of the duty unit.
`timescale 1ns/100ps
`default_nettype none
module pdu_monitor (
  // Clock and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // Gate drive
  input wire logic [3:0] high_side_output,
  input wire logic [3:0] low_side_output,
  input wire logic single_pulse_done
);
  logic a_q;
  logic w_q;
  logic [3:0] x_q;
  logic [3:0] m0_q;
  logic [3:0] m1_q;
  logic [3:0] m2_q;
  logic [15:0] d_q [4];
  logic [15:0] t_q;
  // Gap checks apply once both dead-times are non-zero; a zero dead-time switches both sides in one clock.
  wire dt_on = (t_q[5:0] != 6'h00) && (t_q[13:8] != 6'h00);
  // The mode mask is kept three deep so the output pipeline can settle after a mode write.
  wire [3:0] cm = ~(m0_q | m1_q | m2_q);
  wire [3:0] im = m0_q & m1_q & m2_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_q <= 1'b0;
      w_q <= 1'b0;
      x_q <= 4'h0;
      m0_q <= 4'h0;
      m1_q <= 4'h0;
      m2_q <= 4'h0;
      d_q <= '{default: 16'h0000};
      t_q <= 16'h0000;
    end else begin
      a_q <= hsel & hready & htrans[1] & ~|haddr[31:6];
      w_q <= hwrite;
      x_q <= haddr[5:2];
      m1_q <= m0_q;
      m2_q <= m1_q;
      if (a_q && w_q && x_q == 4'h3) m0_q <= hwdata[3:0];
      if (a_q && w_q && x_q == 4'h5) t_q <= hwdata[15:0];
      if (a_q && w_q && x_q[3:2] == 2'b10) d_q[x_q[1:0]] <= hwdata[15:0];
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  dbuf_read_a: assert property (a_q && !w_q && x_q[3:2] == 2'b10 |-> hrdata == {16'h0000, d_q[x_q[1:0]]})
    else $error("duty buffer readback wrong");
  no_shoot_a: assert property ((high_side_output & low_side_output & cm) == 4'h0)
    else $error("both gates of a complementary pair on");
  hi_gap_a: assert property (dt_on |-> (high_side_output & ~$past(high_side_output) & $past(low_side_output) & cm) == 4'h0)
    else $error("high side rose while low side still on");
  lo_gap_a: assert property (dt_on |-> (low_side_output & ~$past(low_side_output) & $past(high_side_output) & cm) == 4'h0)
    else $error("low side rose while high side still on");
  indep_eq_a: assert property (((high_side_output ^ low_side_output) & im) == 4'h0)
    else $error("independent pair outputs differ");
  done_once_a: assert property (single_pulse_done |=> !single_pulse_done)
    else $error("pulse end flag longer than one cycle");
  done_off_a: assert property (single_pulse_done |-> ##[0:3] high_side_output == 4'h0)
    else $error("outputs still active after pulse end");
  rst_quiet_a: assert property ($rose(hresetn) |-> high_side_output == 4'h0 && low_side_output == 4'h0)
    else $error("outputs active right after reset");
  c_done: cover property (single_pulse_done);
  c_rise: cover property ($rose(high_side_output[3]));
  c_read: cover property (a_q && !w_q);
endmodule // pdu_monitor
`default_nettype wire

/* testbench/pdu_gate_model.sv */
// Gate driver model: one half bridge per output pair.
`timescale 1ns/100ps
`default_nettype none
module pdu_gate_model (
  // Gates
  input wire logic hclk,
  input wire logic [3:0] gate_hi,
  input wire logic [3:0] gate_lo,
  input wire logic [3:0] bridge_mask,
  // Bridge state
  output logic [3:0] node,
  output int shorts
);
  initial node = 4'h0;
  initial shorts = 0;
  // A floating node keeps no value, so it toggles rather than hold the last level.
  always @(posedge hclk) begin
    for (int i = 0; i < 4; i++) begin
      if (gate_hi[i] && gate_lo[i] && bridge_mask[i]) shorts = shorts + 1;
      node[i] = gate_hi[i] ? 1'b1 : gate_lo[i] ? 1'b0 : ~node[i];
    end
  end
endmodule // pdu_gate_model
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking testbench of the duty and dead-time unit.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic rd_ph = 1'b0;
  logic [3:0] cm = 4'hF;
  logic [31:0] rnd = 32'h1929_4246;
  logic [31:0] exq[$];
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire spd;
  wire [3:0] hs;
  wire [3:0] ls;
  wire [3:0] nodes;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int shorts;
  int nd;
  int nh[4];
  int nl[4];
  int eh[4] = '{12, 0, 80, 32};
  int el[4] = '{12, 0, 80, 24};
  logic [1:0] md[4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  pdu_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .high_side_output(hs), .low_side_output(ls), .single_pulse_done(spd));
  pdu_gate_model GM (.hclk(hclk), .gate_hi(hs), .gate_lo(ls), .bridge_mask(cm), .node(nodes), .shorts(shorts));
  always #25 hclk = ~hclk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    rd_ph <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exq.push_back({16'h0000, e});
    bus(1'b0, a, 16'h0000);
  endtask
  task automatic clr;
    @(negedge hclk);
    nd = 0;
    foreach (nh[i]) begin
      nh[i] = 0;
      nl[i] = 0;
    end
  endtask
  // Read results are compared here, one note per data phase, in issue order.
  always @(posedge hclk) begin
    cyc++;
    nd += spd;
    for (int i = 0; i < 4; i++) begin
      nh[i] += hs[i];
      nl[i] += ls[i];
    end
    if (rd_ph) chk("read data", hrdata, exq.pop_front());
    if (cyc == 6000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 4; i++) rd(8'h20 + 8'(4 * i), 16'h0000);
    rd(8'h0C, 16'h0000);
    wr(8'h40, 16'hFFFF);
    rd(8'h40, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, {14'h0000, md[k]});
      wr(8'h10, 16'h0001);
      rnd = lfsr(rnd);
      wr(8'h20 + 8'(4 * k), rnd[15:0]);
      rd(8'h20 + 8'(4 * k), rnd[15:0]);
      rd(8'h30 + 8'(4 * k), md[k][0] ? rnd[15:0] : 16'h0000);
      wr(8'h10, 16'h0000);
      rd(8'h30 + 8'(4 * k), rnd[15:0]);
    end
    cm = 4'h8;
    wr(8'h0C, 16'h0007);
    wr(8'h14, 16'h4202);
    wr(8'h18, 16'h0080);
    wr(8'h20, 16'h0003);
    wr(8'h24, 16'h0000);
    wr(8'h28, 16'h0015);
    wr(8'h2C, 16'h000A);
    wr(8'h04, 16'h0009);
    wr(8'h00, 16'h8000);
    repeat (60) @(posedge hclk);
    clr();
    repeat (80) @(negedge hclk);
    for (int i = 0; i < 4; i++) begin
      chk("high count", nh[i], eh[i]);
      chk("low count", nl[i], el[i]);
    end
    wr(8'h10, 16'h0001);
    wr(8'h20, 16'h0005);
    repeat (45) @(posedge hclk);
    rd(8'h30, 16'h0003);
    wr(8'h10, 16'h0000);
    repeat (45) @(posedge hclk);
    rd(8'h30, 16'h0005);
    for (int k = 1; k < 3; k++) begin
      wr(8'h00, {14'h0000, md[k]});
      wr(8'h00, {14'h2000, md[k]});
      wr(8'h24, k == 1 ? 16'h0007 : 16'h0009);
      repeat (90) @(posedge hclk);
      rd(8'h34, k == 1 ? 16'h0007 : 16'h0009);
    end
    // A first pulse leaves the count cleared, so the measured one starts from zero.
    wr(8'h00, 16'h8002);
    repeat (60) @(posedge hclk);
    rd(8'h08, 16'h0000);
    wr(8'h20, 16'h0003);
    clr();
    wr(8'h00, 16'h8002);
    repeat (60) @(negedge hclk);
    chk("pulse end count", nd, 1);
    chk("pulse width", nh[0], 3);
    chk("high after pulse", {28'h000_0000, hs}, 32'h0000_0000);
    chk("pair four node", {31'h0000_0000, nodes[3]}, 32'h0000_0000);
    rd(8'h00, 16'h0002);
    chk("shoot through", shorts, 0);
    tally_and_finish();
  end
endmodule // tb_top
bind pdu_top pdu_monitor MON (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .high_side_output(high_side_output),
  .low_side_output(low_side_output), .single_pulse_done(single_pulse_done));
`default_nettype wire
